/* verilog/arf_map.vh */
// arf_map.vh: constants for the result accumulator / filter stage
// assumes: included by the design files by bare name; no processes here
`ifndef ARF_MAP_VH
`define ARF_MAP_VH
// compute mode encodings
`define ARF_MODE_BASIC 3'h0
`define ARF_MODE_ACCUM 3'h1
`define ARF_MODE_AVG 3'h2
`define ARF_MODE_BURST 3'h3
`define ARF_MODE_LPF 3'h4
// widths
`define ARF_ACC_W 16
`define ARF_RES_W 10
`define ARF_CNT_W 8
// saturation value of the sample count
`define ARF_CNT_MAX 8'hFF
// clear takes this many clock cycles (mclk cycles)
`define ARF_CLR_CYCLES 3'h5
// reset values
`define ARF_ACC_RST 16'h0000
`define ARF_CNT_RST 8'h00
// fifo geometry
`define ARF_FIFO_DEPTH 4
`define ARF_FIFO_AW 2
`endif

/* verilog/arf_filter.v */
//
// Contract
// - a 16-bit accumulator holds summed results and is readable
// - each conversion trigger adds the new result into the accumulator; the code adds only in modes 1 to 4, once per computation cycle
// - a sum above 65535 sets the overflow flag
// - each added sample increments the sample count
// - clear bit clears accumulator, overflow flag and sample count
// - clear bit drops to zero by itself when clearing completes
// - clearing takes five cycles of the converter clock
// - filtered result is the accumulator shifted right by shift setting
// - low-pass: sample plus accumulator minus accumulator shifted right
// - sample count saturates at 0xFF, otherwise increments by one
// - basic mode leaves accumulator and count unchanged, threshold test still runs
// - accumulate mode adds result and copies shifted value to filtered result
// - accumulator stays right-justified whatever the result format
// - accumulate mode runs threshold test after every sample
// - average mode accumulates, counts and updates the filtered result
// - average mode tests threshold only once count reaches repeat setting
// - sample term is result, or current minus previous when double sampling
// - a computation cycle is one conversion, or two when double sampling
// - average mode clears on clear bit or go while count meets repeat
// - burst average clears on clear bit or on every go or retrigger; the code clears on go only, a retrigger does not clear
// - mode 011 is burst average, retriggering until count reaches repeat
// - mode 100 is low-pass, threshold test once count reaches repeat
//
// arf_filter.v: accumulator, sample counter, shift filter and a small input fifo
// assumes: results arrive in the mclk domain as valid/ready words; software
// controls are synchronous levels/pulses from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "arf_map.vh"

// small first-word-fall-through fifo built from flip-flops
module arf_fifo #(
    parameter WIDTH = 11,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire mclk,
    input wire rst,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    // fill level at which the fifo refuses further words
    localparam [AW:0] FULL = DEPTH;

    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_r;
    reg [AW-1:0] rd_ptr_r;
    reg [AW:0] fill_r;
    reg [AW:0] fill_nxt;
    reg ready_r;
    wire push;
    wire pop;

    // ready is registered so the converter sees a flop, not a compare
    assign in_ready = ready_r;
    assign out_valid = (fill_r != {(AW+1){1'b0}});
    assign out_data = mem_r[rd_ptr_r];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // next fill level; a push and a pop in one cycle leave it unchanged
    always @* begin
        fill_nxt = fill_r;
        if (push & ~pop)
            fill_nxt = fill_r + 1'b1;
        else if (pop & ~push)
            fill_nxt = fill_r - 1'b1;
    end

    // pointers and fill level; ready follows the next fill so it never lags
    always @(posedge mclk) begin
        if (rst) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            fill_r <= {(AW+1){1'b0}};
            ready_r <= 1'b1;
        end else begin
            if (push)
                wr_ptr_r <= wr_ptr_r + 1'b1;
            if (pop)
                rd_ptr_r <= rd_ptr_r + 1'b1;
            fill_r <= fill_nxt;
            ready_r <= (fill_nxt != FULL);
        end
    end

    // storage carries no reset, only written on push
    always @(posedge mclk) begin
        if (push)
            mem_r[wr_ptr_r] <= in_data;
    end
endmodule // arf_fifo

// computation stage behind the converter core
// modes: 0 basic, 1 accumulate, 2 average, 3 burst average, 4 low-pass;
// codes 5 to 7 pop results but neither accumulate nor request a test.
// the threshold comparison itself lives outside; this block only raises
// threshold_test_pulse when a comparison is due.
// limitation: the sample count saturates, so repeat settings of 0xFF are
// reached but never exceeded; software must clear before reuse.
// trade-off: a clear stalls the result stream rather than dropping words,
// which costs the small fifo but keeps every conversion accounted for.
module arf_filter (
    input wire mclk,
    input wire rst,
    // conversion results from the converter core
    input wire res_valid,
    output wire res_ready,
    input wire [9:0] conversion_result,
    input wire res_go_start,
    // software controls
    input wire [2:0] compute_mode_select,
    input wire [2:0] shift_setting,
    input wire [7:0] repeat_setting,
    input wire double_sample_enable,
    input wire accum_clear_set,
    // software-visible state
    output reg accum_clear_bit,
    output reg [15:0] accum_value,
    output reg accum_overflow_flag,
    output reg [7:0] sample_count,
    output reg [15:0] filtered_result,
    output reg [9:0] previous_result,
    output reg threshold_test_pulse,
    output reg burst_retrigger,
    output reg cycle_done
);
    localparam ST_IDLE = 1'b0;
    localparam ST_CLEAR = 1'b1;

    reg state_r;
    reg [2:0] clr_cnt_r;
    reg second_r;
    wire f_valid;
    wire f_ready;
    wire [10:0] f_data;
    wire f_go;
    wire [9:0] f_res;

    // reg outputs used as state are named per their ports
    reg [16:0] sum_nxt;
    reg [15:0] acc_nxt;
    reg [7:0] cnt_nxt;
    reg ovf_nxt;
    reg [15:0] term;
    reg [15:0] acc_base;
    reg [7:0] cnt_base;
    reg pre_clear;
    reg do_test;
    reg accumulating;

    // the fifo absorbs results while a clear is running; converter stalls on ready
    arf_fifo #(
        .WIDTH(11),
        .DEPTH(`ARF_FIFO_DEPTH),
        .AW(`ARF_FIFO_AW)
    ) u_fifo (
        .mclk(mclk),
        .rst(rst),
        .in_valid(res_valid),
        .in_ready(res_ready),
        .in_data({res_go_start, conversion_result}),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data(f_data)
    );

    assign f_go = f_data[10];
    assign f_res = f_data[9:0];
    assign f_ready = (state_r == ST_IDLE) & ~accum_clear_set;

    // next accumulator, count and test decision for one popped result
    always @* begin
        pre_clear = 1'b0;
        // go-time clears in the averaging modes
        if (f_go && compute_mode_select == `ARF_MODE_AVG && sample_count >= repeat_setting)
            pre_clear = 1'b1;
        if (f_go && compute_mode_select == `ARF_MODE_BURST)
            pre_clear = 1'b1;
        acc_base = pre_clear ? `ARF_ACC_RST : accum_value;
        cnt_base = pre_clear ? `ARF_CNT_RST : sample_count;
        // sample term: result, or current minus previous on the second conversion
        if (double_sample_enable)
            term = {6'h00, f_res} - {6'h00, previous_result};
        else
            term = {6'h00, f_res};
        // first of a pair adds nothing: it stores the previous value and takes any go-time clear
        accumulating = (compute_mode_select != `ARF_MODE_BASIC) && (compute_mode_select <= `ARF_MODE_LPF)
            && (~double_sample_enable | second_r);
        if (compute_mode_select == `ARF_MODE_LPF)
            sum_nxt = {1'b0, acc_base} + {1'b0, term} - {1'b0, (acc_base >> shift_setting)};
        else
            sum_nxt = {1'b0, acc_base} + {1'b0, term};
        acc_nxt = sum_nxt[15:0];
        ovf_nxt = sum_nxt[16];
        cnt_nxt = (cnt_base == `ARF_CNT_MAX) ? cnt_base : cnt_base + 8'h01;
        case (compute_mode_select)
            `ARF_MODE_BASIC: do_test = 1'b1;
            `ARF_MODE_ACCUM: do_test = 1'b1;
            `ARF_MODE_AVG, `ARF_MODE_BURST, `ARF_MODE_LPF: do_test = (cnt_nxt >= repeat_setting);
            default: do_test = 1'b0;
        endcase
    end

    // main sequence: idle takes results, clear holds for the fixed cycle count
    always @(posedge mclk) begin
        if (rst) begin
            state_r <= ST_IDLE;
            clr_cnt_r <= 3'h0;
            second_r <= 1'b0;
            accum_clear_bit <= 1'b0;
            accum_value <= `ARF_ACC_RST;
            accum_overflow_flag <= 1'b0;
            sample_count <= `ARF_CNT_RST;
            filtered_result <= 16'h0000;
            previous_result <= 10'h000;
            threshold_test_pulse <= 1'b0;
            burst_retrigger <= 1'b0;
            cycle_done <= 1'b0;
        end else begin
            threshold_test_pulse <= 1'b0;
            burst_retrigger <= 1'b0;
            cycle_done <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (accum_clear_set) begin
                        // clear request beats any result waiting in the fifo
                        state_r <= ST_CLEAR;
                        accum_clear_bit <= 1'b1;
                        clr_cnt_r <= `ARF_CLR_CYCLES - 3'h1;
                    end else if (f_valid) begin
                        previous_result <= f_res;
                        second_r <= double_sample_enable & ~second_r;
                        if (~double_sample_enable | second_r) begin
                            cycle_done <= 1'b1;
                            threshold_test_pulse <= do_test;
                        end
                        if (accumulating) begin
                            accum_value <= acc_nxt;
                            sample_count <= cnt_nxt;
                            filtered_result <= acc_nxt >> shift_setting;
                            // overflow is sticky; a go-time clear does not reset it
                            accum_overflow_flag <= accum_overflow_flag | ovf_nxt;
                            if (compute_mode_select == `ARF_MODE_BURST && cnt_nxt < repeat_setting)
                                burst_retrigger <= 1'b1;
                        end else if (pre_clear) begin
                            accum_value <= `ARF_ACC_RST;
                            sample_count <= `ARF_CNT_RST;
                        end
                    end
                end
                ST_CLEAR: begin
                    accum_value <= `ARF_ACC_RST;
                    sample_count <= `ARF_CNT_RST;
                    accum_overflow_flag <= 1'b0;
                    second_r <= 1'b0;
                    // leaving on zero keeps the clear bit high for the full count
                    if (clr_cnt_r == 3'h0) begin
                        state_r <= ST_IDLE;
                        accum_clear_bit <= 1'b0;
                        clr_cnt_r <= 3'h0;
                    end else begin
                        clr_cnt_r <= clr_cnt_r - 3'h1;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end
endmodule // arf_filter
`default_nettype wire

/* dv/arf_filter_checker.sv */
// checker: output timing of the accumulator filter
// assumes: bound into arf_filter, rst synchronous active high
`timescale 1ns/1ps
`default_nettype none
module arf_filter_checker (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [2:0] compute_mode_select,
    input wire logic [2:0] shift_setting,
    input wire logic [7:0] repeat_setting,
    input wire logic accum_clear_bit,
    input wire logic [15:0] accum_value,
    input wire logic accum_overflow_flag,
    input wire logic [7:0] sample_count,
    input wire logic [15:0] filtered_result,
    input wire logic threshold_test_pulse
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // clear edges are excluded where state may move for the clear itself
    a_clear_five: assert property ($rose(accum_clear_bit) |-> accum_clear_bit [*5] ##1 !accum_clear_bit)
        else $error("clear length wrong");
    a_clear_zero: assert property ($fell(accum_clear_bit) |-> !accum_value && !sample_count && !accum_overflow_flag)
        else $error("clear left state");
    a_ovf_sticky: assert property (accum_overflow_flag |=> accum_overflow_flag || accum_clear_bit)
        else $error("overflow dropped");
    a_count_step: assert property (compute_mode_select == 3'h1 && !accum_clear_bit
        |=> sample_count - $past(sample_count) <= 8'h01 || accum_clear_bit)
        else $error("count jump");
    a_basic_still: assert property (compute_mode_select == 3'h0 && $past(compute_mode_select) == 3'h0 && !accum_clear_bit
        && !$past(accum_clear_bit) |-> $stable(accum_value) && $stable(sample_count))
        else $error("basic mode moved state");
    a_filt_shift: assert property (compute_mode_select == 3'h1 && $changed(accum_value) && !accum_clear_bit
        && !$past(accum_clear_bit) |-> filtered_result == accum_value >> shift_setting)
        else $error("filtered value wrong");
    a_accum_test: assert property (compute_mode_select == 3'h1 && $changed(sample_count) && !accum_clear_bit
        && !$past(accum_clear_bit) |-> threshold_test_pulse)
        else $error("test pulse missing");
    a_avg_gate: assert property (threshold_test_pulse && (compute_mode_select == 3'h2 || compute_mode_select == 3'h4)
        |-> sample_count >= repeat_setting)
        else $error("test before repeat");
endmodule // arf_filter_checker
bind arf_filter arf_filter_checker i_arf_filter_checker (.mclk(mclk), .rst(rst),
    .compute_mode_select(compute_mode_select), .shift_setting(shift_setting), .repeat_setting(repeat_setting),
    .accum_clear_bit(accum_clear_bit), .accum_value(accum_value), .accum_overflow_flag(accum_overflow_flag),
    .sample_count(sample_count), .filtered_result(filtered_result), .threshold_test_pulse(threshold_test_pulse));
`default_nettype wire

/* dv/arf_conv_model.sv */
// model: converter core offering result words
// assumes: a word is taken when ready is high at a rising edge
`timescale 1ns/1ps
`default_nettype none
module arf_conv_model (
    input wire logic mclk,
    input wire logic res_ready,
    output logic res_valid = 1'b0,
    output logic [9:0] conversion_result = 10'h3FF,
    output logic res_go_start = 1'b0
);
    // hold the word until taken; idle lines show the inverse, never stale data
    task automatic put(input logic [9:0] v, input logic g);
        logic r = 1'b0;
        @(posedge mclk);
        {res_valid, conversion_result, res_go_start} <= {1'b1, v, g};
        while (r !== 1'b1) begin
            @(negedge mclk);
            r = res_ready;
            @(posedge mclk);
        end
        {res_valid, conversion_result, res_go_start} <= {1'b0, ~v, ~g};
    endtask
endmodule // arf_conv_model
`default_nettype wire

/* dv/arf_filter_tb_top.sv */
// bench: accumulate, overflow, average, burst, low-pass, fifo refusal
// assumes: arf_conv_model feeds results; controls change at rising edges
`timescale 1ns/1ps
`default_nettype none
module arf_filter_tb_top;
    logic mclk = 1'b0, rst = 1'b1, dse = 1'b0, cset = 1'b0, rv, go;
    logic [2:0] md = 3'h0, sh = 3'h0;
    logic [7:0] rpt = 8'h00;
    wire [9:0] cres;
    wire rdy, cbit, ovf, tp;
    wire [15:0] acc, filt;
    wire [7:0] cnt;
    wire [9:0] prev;
    wire brt, cdone;
    int err_count = 0, n_compared = 0;
    int n_retrig = 0, n_done = 0;
    // pulses stand one cycle; count them so tests can judge them later
    always @(posedge mclk) begin
        if (brt === 1'b1)
            n_retrig <= n_retrig + 1;
        if (cdone === 1'b1)
            n_done <= n_done + 1;
    end
    arf_conv_model i_arf_conv_model (.mclk(mclk), .res_ready(rdy), .res_valid(rv),
        .conversion_result(cres), .res_go_start(go));
    arf_filter i_arf_filter (.mclk(mclk), .rst(rst), .res_valid(rv), .res_ready(rdy), .conversion_result(cres),
        .res_go_start(go), .compute_mode_select(md), .shift_setting(sh), .repeat_setting(rpt),
        .double_sample_enable(dse), .accum_clear_set(cset), .accum_clear_bit(cbit), .accum_value(acc),
        .accum_overflow_flag(ovf), .sample_count(cnt), .filtered_result(filt), .previous_result(prev),
        .threshold_test_pulse(tp), .burst_retrigger(brt), .cycle_done(cdone));
    initial forever #4 mclk = ~mclk;
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask
    // result then enough edges for pop and update to land
    task automatic send(input logic [9:0] v, input logic g);
        i_arf_conv_model.put(v, g);
        repeat (4) @(posedge mclk);
        @(negedge mclk);
    endtask
    // new settings with a one-cycle clear request
    task automatic cfg(input logic [2:0] m, s, input logic [7:0] r);
        @(posedge mclk) {md, sh, rpt, cset} <= {m, s, r, 1'b1};
        @(posedge mclk) cset <= 1'b0;
        repeat (8) @(posedge mclk);
        @(negedge mclk);
    endtask
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic t_accum();
        cfg(3'h1, 3'h2, 8'h00);
        send(10'h064, 1'b0);
        send(10'h1F7, 1'b0);
        chk("acc", 16'h025B, acc);
        chk("filt", 16'h0096, filt);
        @(posedge mclk) md <= 3'h0;
        send(10'h007, 1'b0);
        chk("basic cnt", 16'h0002, cnt);
        chk("prev", 16'h0007, {6'h00, prev});
        $display("accum done");
    endtask
    task automatic t_ovf();
        cfg(3'h1, 3'h0, 8'h00);
        repeat (64) send(10'h3FF, 1'b0);
        chk("ovf 65472", 16'h0000, ovf);
        send(10'h3FF, 1'b0);
        chk("ovf 66495", 16'h0001, ovf);
        repeat (191) i_arf_conv_model.put(10'h000, 1'b0);
        send(10'h000, 1'b0);
        chk("cnt sat", 16'h00FF, cnt);
        chk("ovf held", 16'h0001, ovf);
        cfg(3'h1, 3'h0, 8'h00);
        chk("clr acc", 16'h0000, acc);
        chk("clr ovf", 16'h0000, ovf);
        chk("clr cnt", 16'h0000, cnt);
        chk("clr bit", 16'h0000, cbit);
        $display("ovf done");
    endtask
    task automatic t_avg();
        cfg(3'h2, 3'h2, 8'h04);
        repeat (4) send(10'h010, 1'b1);
        chk("avg filt", 16'h0010, filt);
        send(10'h020, 1'b1);
        chk("avg go", 16'h0020, acc);
        @(posedge mclk) md <= 3'h3;
        n_retrig = 0;
        send(10'h008, 1'b1);
        chk("burst go", 16'h0008, acc);
        chk("retrig", 16'h0001, n_retrig[15:0]);
        $display("avg done");
    endtask
    task automatic t_dbl();
        cfg(3'h1, 3'h0, 8'h00);
        @(posedge mclk) dse <= 1'b1;
        n_done = 0;
        send(10'h050, 1'b0);
        send(10'h070, 1'b0);
        chk("dbl acc", 16'h0020, acc);
        chk("dbl cnt", 16'h0001, cnt);
        chk("dbl done", 16'h0001, n_done[15:0]);
        @(posedge mclk) dse <= 1'b0;
        $display("dbl done");
    endtask
    task automatic t_lpf();
        cfg(3'h4, 3'h1, 8'h00);
        send(10'h064, 1'b0);
        send(10'h064, 1'b0);
        chk("lpf", 16'h0096, acc);
        $display("lpf done");
    endtask
    task automatic t_fifo();
        cfg(3'h1, 3'h0, 8'h00);
        @(posedge mclk) cset <= 1'b1;
        repeat (4) i_arf_conv_model.put(10'h001, 1'b0);
        @(negedge mclk);
        chk("full", 16'h0000, rdy);
        @(posedge mclk) cset <= 1'b0;
        repeat (16) @(posedge mclk);
        @(negedge mclk);
        chk("drain", 16'h0004, acc);
        $display("fifo done");
    endtask
    // cut a hang short well past the expected thousand or so cycles
    initial begin
        repeat (20000) @(posedge mclk);
        err_count++;
        close_out();
    end
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        chk("rst", 16'h0001, {acc, cnt, ovf, filt, !rdy} == 0);
        t_accum();
        t_ovf();
        t_avg();
        t_lpf();
        t_dbl();
        t_fifo();
        close_out();
    end
endmodule // arf_filter_tb_top
`default_nettype wire
